//--- logic/slcr_regs.sv
// Serializer link configuration registers 0x14 to 0x1A
`timescale 1ns/1ps
module slcr_regs
    import slcr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic general_out_immunity_strap,
    input wire logic high_bw_mode,
    input wire logic de_in,
    input wire logic hs_n_in,
    input wire logic [1:0] dual_pin_in,
    output logic [3:0] coax_swing_level,
    output logic swing_code_bad,
    output logic remote_wake_off,
    output logic wake_rx_en,
    output logic de_packet_trigger_off,
    output logic [1:0] ctrl_packet_trigger_sel,
    output logic ctrl_packet_send,
    output logic rev_chan_pos_en,
    output logic rev_chan_neg_en,
    output logic robust_rev_chan_sel,
    output logic robust_rev_rate_sel,
    output logic [7:0] rev_bit_cycles,
    output logic pin_a_role_sel,
    output logic pin_b_role_sel,
    output logic mode_select_input,
    output logic aux_control_bit0,
    output logic link_side_select_input,
    output logic aux_control_bit3
);

    // ************************************************************
    // Stored fields
    // ************************************************************
    logic [3:0] swing_q;
    logic wake_off_q;
    logic de_off_q;
    logic [1:0] trig_sel_q;
    logic rev_pos_q;
    logic rev_neg_q;
    logic robust_q;
    logic rate_q;
    logic role_a_q;
    logic role_b_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic bad_q;
    logic wake_en_q;
    logic send_q;
    logic [7:0] bit_cyc_q;
    logic strap_load;
    logic strap_value;
    logic imm_written_q;
    logic strap_apply;

    // ************************************************************
    // Address decode
    // ************************************************************
    logic hit_swing;
    logic hit_trigger;
    logic hit_immunity;
    logic hit_rate;
    logic wr_swing;
    logic wr_trigger;
    logic wr_immunity;
    logic wr_rate;

    // One hit line per writable register
    assign hit_swing = (reg_addr == ADDR_SWING);
    assign hit_trigger = (reg_addr == ADDR_TRIGGER);
    assign hit_immunity = (reg_addr == ADDR_IMMUNITY);
    assign hit_rate = (reg_addr == ADDR_RATE_ROLES);
    assign wr_swing = reg_wr & hit_swing;
    assign wr_trigger = reg_wr & hit_trigger;
    assign wr_immunity = reg_wr & hit_immunity;
    assign wr_rate = reg_wr & hit_rate;

    // ************************************************************
    // Read-back images with fixed reserved bits
    // ************************************************************
    logic [7:0] img_swing;
    logic [7:0] img_trigger;
    logic [7:0] img_immunity;
    logic [7:0] img_rate;
    logic [7:0] rd_mux;

    // Assemble each register as software sees it
    assign img_swing = {swing_q, SWING_RSVD, wake_off_q};
    assign img_trigger = {de_off_q, trig_sel_q, rev_pos_q, rev_neg_q,
                          TRIGGER_RSVD};
    assign img_immunity = {robust_q, IMMUNITY_RSVD};
    assign img_rate = {rate_q, 1'b0, role_a_q, role_b_q, 4'h0};

    // Read selection; unmapped addresses read zero
    always_comb begin
        if (reg_addr == ADDR_SWING) begin
            rd_mux = img_swing;
        end else if (reg_addr == ADDR_TRIGGER) begin
            rd_mux = img_trigger;
        end else if (reg_addr == ADDR_RSVD_A) begin
            rd_mux = RSVD_A_VALUE;
        end else if (reg_addr == ADDR_IMMUNITY) begin
            rd_mux = img_immunity;
        end else if (reg_addr == ADDR_RSVD_RO) begin
            rd_mux = RSVD_RO_VALUE;
        end else if (reg_addr == ADDR_RSVD_B) begin
            rd_mux = RSVD_B_VALUE;
        end else if (reg_addr == ADDR_RATE_ROLES) begin
            rd_mux = img_rate;
        end else begin
            rd_mux = UNMAPPED_VALUE;
        end
    end

    // ************************************************************
    // Strap capture for the immunity default
    // ************************************************************
    slcr_strap_capture u_strap (
        .clk(clk),
        .sys_rst(sys_rst),
        .strap_pin(general_out_immunity_strap),
        .load_pulse(strap_load),
        .load_value(strap_value)
    );

    // Strap default counts only until software picks a mode
    // Capture lands a few cycles after release, so it must not undo a write
    assign strap_apply = strap_load & ~imm_written_q;

    // ************************************************************
    // Register writes
    // ************************************************************

    // Swing and wake register; reserved bits ignore writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            swing_q <= SWING_RESET;
            wake_off_q <= 1'b0;
        end else if (wr_swing) begin
            swing_q <= reg_wdata[SWING_MSB:SWING_LSB];
            wake_off_q <= reg_wdata[WAKE_OFF_BIT];
        end
    end

    // Packet trigger and reverse input register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            de_off_q <= 1'b0;
            trig_sel_q <= TRIG_SEL_RESET;
            rev_pos_q <= 1'b1;
            rev_neg_q <= 1'b0;
        end else if (wr_trigger) begin
            de_off_q <= reg_wdata[DE_TRIG_OFF_BIT];
            trig_sel_q <= reg_wdata[TRIG_SEL_MSB:TRIG_SEL_LSB];
            rev_pos_q <= reg_wdata[REV_POS_BIT];
            rev_neg_q <= reg_wdata[REV_NEG_BIT];
        end
    end

    // Immunity select; a software write beats the strap load
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            robust_q <= 1'b0;
            imm_written_q <= 1'b0;
        end else if (wr_immunity) begin
            robust_q <= reg_wdata[ROBUST_SEL_BIT];
            imm_written_q <= 1'b1;
        end else if (strap_apply) begin
            robust_q <= strap_value;
        end
    end

    // Rate and pin role register; bits 3 to 0 are not kept
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rate_q <= 1'b0;
            role_a_q <= 1'b0;
            role_b_q <= 1'b0;
        end else if (wr_rate) begin
            rate_q <= reg_wdata[RATE_SEL_BIT];
            role_a_q <= reg_wdata[PIN_A_ROLE_BIT];
            role_b_q <= reg_wdata[PIN_B_ROLE_BIT];
        end
    end

    // Read data, one cycle after the read strobe
    // Read data holds between reads; rvalid marks the fresh byte
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ************************************************************
    // Derived control for the link logic
    // ************************************************************
    logic swing_ok;
    logic de_trig;
    logic send_d;
    logic robust_fast;
    logic [7:0] bit_cyc_d;

    // Codes outside 1 to 10 are not usable swing levels
    assign swing_ok = (swing_q >= SWING_MIN_CODE) &&
                      (swing_q <= SWING_MAX_CODE);

    // Data-enable low trigger unless suppressed
    assign de_trig = ~de_in & ~de_off_q;

    // Rate select counts only in high-immunity operation
    assign robust_fast = robust_q & rate_q;
    assign bit_cyc_d = robust_fast ? BIT_CYC_FAST : BIT_CYC_SLOW;

    // Packet send request in high-bandwidth mode
    always_comb begin
        case (trig_sel_q)
            TRIG_NEVER: send_d = 1'b0;
            TRIG_ALWAYS: send_d = 1'b1;
            TRIG_DE_LOW: send_d = de_trig;
            default: send_d = ~hs_n_in;
        endcase
    end

    // Registered status and control outputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bad_q <= 1'b0;
            wake_en_q <= 1'b1;
            send_q <= 1'b0;
            bit_cyc_q <= BIT_CYC_SLOW;
        end else begin
            bad_q <= ~swing_ok;
            wake_en_q <= ~wake_off_q;
            send_q <= high_bw_mode & send_d;
            bit_cyc_q <= bit_cyc_d;
        end
    end

    // ************************************************************
    // Dual purpose pins
    // ************************************************************
    slcr_pin_route u_pins (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(dual_pin_in),
        .pin_a_role(role_a_q),
        .pin_b_role(role_b_q),
        .mode_select_input(mode_select_input),
        .aux_control_bit0(aux_control_bit0),
        .link_side_select_input(link_side_select_input),
        .aux_control_bit3(aux_control_bit3)
    );

    // ************************************************************
    // Output assignments, all from flip-flops
    // ************************************************************
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign coax_swing_level = swing_q;
    assign swing_code_bad = bad_q;
    assign remote_wake_off = wake_off_q;
    assign wake_rx_en = wake_en_q;
    assign de_packet_trigger_off = de_off_q;
    assign ctrl_packet_trigger_sel = trig_sel_q;
    assign ctrl_packet_send = send_q;
    assign rev_chan_pos_en = rev_pos_q;
    assign rev_chan_neg_en = rev_neg_q;
    assign robust_rev_chan_sel = robust_q;
    assign robust_rev_rate_sel = rate_q;
    assign rev_bit_cycles = bit_cyc_q;
    assign pin_a_role_sel = role_a_q;
    assign pin_b_role_sel = role_b_q;

endmodule

//--- logic/slcr_pkg.sv
// Constants and types shared by the serializer link configuration registers
package slcr_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_SWING = 8'h14;
    localparam logic [7:0] ADDR_TRIGGER = 8'h15;
    localparam logic [7:0] ADDR_RSVD_A = 8'h16;
    localparam logic [7:0] ADDR_IMMUNITY = 8'h17;
    localparam logic [7:0] ADDR_RSVD_RO = 8'h18;
    localparam logic [7:0] ADDR_RSVD_B = 8'h19;
    localparam logic [7:0] ADDR_RATE_ROLES = 8'h1A;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SWING_MSB = 7;
    localparam int SWING_LSB = 4;
    localparam int WAKE_OFF_BIT = 0;
    localparam int DE_TRIG_OFF_BIT = 7;
    localparam int TRIG_SEL_MSB = 6;
    localparam int TRIG_SEL_LSB = 5;
    localparam int REV_POS_BIT = 4;
    localparam int REV_NEG_BIT = 3;
    localparam int ROBUST_SEL_BIT = 7;
    localparam int RATE_SEL_BIT = 7;
    localparam int PIN_A_ROLE_BIT = 5;
    localparam int PIN_B_ROLE_BIT = 4;

    // ************************************************************
    // Reset values and fixed reserved contents
    // ************************************************************
    localparam logic [3:0] SWING_RESET = 4'hA;
    localparam logic [3:0] SWING_MIN_CODE = 4'h1;
    localparam logic [3:0] SWING_MAX_CODE = 4'hA;
    localparam logic [2:0] SWING_RSVD = 3'h0;
    localparam logic [1:0] TRIG_SEL_RESET = 2'h2;
    localparam logic [2:0] TRIGGER_RSVD = 3'h2;
    localparam logic [6:0] IMMUNITY_RSVD = 7'h1F;
    localparam logic [7:0] RSVD_A_VALUE = 8'h00;
    localparam logic [7:0] RSVD_RO_VALUE = 8'h00;
    localparam logic [7:0] RSVD_B_VALUE = 8'h4A;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

    // ************************************************************
    // Control packet trigger selections
    // ************************************************************
    localparam logic [1:0] TRIG_NEVER = 2'h0;
    localparam logic [1:0] TRIG_ALWAYS = 2'h1;
    localparam logic [1:0] TRIG_DE_LOW = 2'h2;
    localparam logic [1:0] TRIG_HS_LOW = 2'h3;

    // ************************************************************
    // Timing: clock and reverse channel bit rates
    // ************************************************************
    localparam int CLK_KHZ = 100000;
    localparam int RATE_SLOW_KBPS = 500;
    localparam int RATE_FAST_KBPS = 1000;
    localparam logic [7:0] BIT_CYC_SLOW = 8'(CLK_KHZ / RATE_SLOW_KBPS);
    localparam logic [7:0] BIT_CYC_FAST = 8'(CLK_KHZ / RATE_FAST_KBPS);
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // Strap capture sequence
    typedef enum logic [1:0] {
        SLCR_ST_SETTLE,
        SLCR_ST_SAMPLE,
        SLCR_ST_DONE
    } slcr_strap_state_type;

endpackage

//--- logic/slcr_strap_capture.sv
// Strap pin synchroniser that loads the immunity default after reset
`timescale 1ns/1ps
module slcr_strap_capture
    import slcr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic strap_pin,
    output logic load_pulse,
    output logic load_value
);

    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic [1:0] wait_q;
    slcr_strap_state_type state_q;
    logic stable;

    // Three stage synchroniser for the strap pin
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= strap_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Level counts once stages two and three agree
    assign stable = (sync2_q == sync3_q);

    // One capture after release, then idle until next reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= SLCR_ST_SETTLE;
            wait_q <= 2'h0;
            load_pulse <= 1'b0;
            load_value <= 1'b0;
        end else begin
            load_pulse <= 1'b0;
            case (state_q)
                SLCR_ST_SETTLE: begin
                    wait_q <= wait_q + 2'h1;
                    if (wait_q == STRAP_SETTLE) begin
                        state_q <= SLCR_ST_SAMPLE;
                    end
                end
                SLCR_ST_SAMPLE: begin
                    if (stable) begin
                        load_pulse <= 1'b1;
                        load_value <= sync3_q;
                        state_q <= SLCR_ST_DONE;
                    end
                end
                default: begin
                    state_q <= SLCR_ST_DONE;
                end
            endcase
        end
    end

endmodule

//--- logic/slcr_pin_route.sv
// Synchronises two dual purpose pins and routes them by their role bits
`timescale 1ns/1ps
module slcr_pin_route
    import slcr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] pin_in,
    input wire logic pin_a_role,
    input wire logic pin_b_role,
    output logic mode_select_input,
    output logic aux_control_bit0,
    output logic link_side_select_input,
    output logic aux_control_bit3
);

    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [1:0] level_q;

    // Per pin three stage synchroniser and agreement filter
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_pin
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sync1_q[i] <= 1'b0;
                    sync2_q[i] <= 1'b0;
                    sync3_q[i] <= 1'b0;
                    level_q[i] <= 1'b0;
                end else begin
                    sync1_q[i] <= pin_in[i];
                    sync2_q[i] <= sync1_q[i];
                    sync3_q[i] <= sync2_q[i];
                    if (sync2_q[i] == sync3_q[i]) begin
                        level_q[i] <= sync3_q[i];
                    end
                end
            end
        end
    endgenerate

    // Role selection; the unselected function holds low
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_select_input <= 1'b0;
            aux_control_bit0 <= 1'b0;
            link_side_select_input <= 1'b0;
            aux_control_bit3 <= 1'b0;
        end else begin
            mode_select_input <= level_q[0] & ~pin_a_role;
            aux_control_bit0 <= level_q[0] & pin_a_role;
            link_side_select_input <= level_q[1] & ~pin_b_role;
            aux_control_bit3 <= level_q[1] & pin_b_role;
        end
    end

endmodule

//--- sim/slcr_regs_properties.sv
// Concurrent checks on the configuration register ports
`timescale 1ns/1ps
module slcr_regs_checker
    import slcr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic high_bw_mode,
    input wire logic de_in,
    input wire logic hs_n_in,
    input wire logic [3:0] coax_swing_level,
    input wire logic swing_code_bad,
    input wire logic remote_wake_off,
    input wire logic wake_rx_en,
    input wire logic de_packet_trigger_off,
    input wire logic [1:0] ctrl_packet_trigger_sel,
    input wire logic ctrl_packet_send,
    input wire logic rev_chan_pos_en,
    input wire logic rev_chan_neg_en,
    input wire logic robust_rev_chan_sel,
    input wire logic robust_rev_rate_sel,
    input wire logic [7:0] rev_bit_cycles,
    input wire logic pin_a_role_sel,
    input wire logic pin_b_role_sel,
    input wire logic mode_select_input,
    input wire logic aux_control_bit0,
    input wire logic link_side_select_input,
    input wire logic aux_control_bit3
);
    // Expected values decoded from the fields
    wire [1:0] sel = ctrl_packet_trigger_sel;
    wire send_exp = high_bw_mode & ((sel == 2'h1) | (sel == 2'h3 & ~hs_n_in)
        | (sel == 2'h2 & ~de_in & ~de_packet_trigger_off));
    wire bad_exp = (coax_swing_level == 4'h0) | (coax_swing_level > 4'hA);
    wire [7:0] cyc_exp = (robust_rev_chan_sel & robust_rev_rate_sel)
        ? BIT_CYC_FAST : BIT_CYC_SLOW;
    wire wr_swing = reg_wr & (reg_addr == ADDR_SWING);
    wire wr_trig = reg_wr & (reg_addr == ADDR_TRIGGER);
    wire wr_rate = reg_wr & (reg_addr == ADDR_RATE_ROLES);

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_swing_wr;
        wr_swing |=> coax_swing_level == $past(reg_wdata[7:4])
            && remote_wake_off == $past(reg_wdata[0]);
    endproperty
    a_swing_wr: assert property (p_swing_wr)
        else $error("swing register write not applied");
    property p_bad;
        1'b1 |=> swing_code_bad == $past(bad_exp);
    endproperty
    a_bad: assert property (p_bad)
        else $error("swing code flag wrong");
    property p_wake;
        1'b1 |=> wake_rx_en != $past(remote_wake_off);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake receiver enable wrong");
    property p_trig_wr;
        wr_trig |=> {de_packet_trigger_off, sel, rev_chan_pos_en,
            rev_chan_neg_en} == $past(reg_wdata[7:3]);
    endproperty
    a_trig_wr: assert property (p_trig_wr)
        else $error("trigger register write not applied");
    property p_trig_hold;
        !wr_trig |=> $stable({sel, rev_chan_pos_en, rev_chan_neg_en});
    endproperty
    a_trig_hold: assert property (p_trig_hold)
        else $error("trigger fields changed without a write");
    property p_send;
        1'b1 |=> ctrl_packet_send == $past(send_exp);
    endproperty
    a_send: assert property (p_send)
        else $error("control packet request wrong");
    property p_cyc;
        1'b1 |=> rev_bit_cycles == $past(cyc_exp);
    endproperty
    a_cyc: assert property (p_cyc)
        else $error("reverse bit period wrong");
    property p_rate_wr;
        wr_rate |=> {robust_rev_rate_sel, pin_a_role_sel, pin_b_role_sel}
            == {$past(reg_wdata[7]), $past(reg_wdata[5:4])};
    endproperty
    a_rate_wr: assert property (p_rate_wr)
        else $error("rate register write not applied");
    property p_pin_a;
        pin_a_role_sel[*3] |-> !mode_select_input;
    endproperty
    a_pin_a: assert property (p_pin_a)
        else $error("mode select driven in control role");
    property p_pin_b;
        (!pin_b_role_sel)[*3] |-> !aux_control_bit3;
    endproperty
    a_pin_b: assert property (p_pin_b)
        else $error("control bit 3 driven in select role");
endmodule

bind slcr_regs slcr_regs_checker chk_u (.clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .high_bw_mode, .de_in, .hs_n_in, .coax_swing_level,
    .swing_code_bad, .remote_wake_off, .wake_rx_en, .de_packet_trigger_off,
    .ctrl_packet_trigger_sel, .ctrl_packet_send, .rev_chan_pos_en,
    .rev_chan_neg_en, .robust_rev_chan_sel, .robust_rev_rate_sel,
    .rev_bit_cycles, .pin_a_role_sel, .pin_b_role_sel, .mode_select_input,
    .aux_control_bit0, .link_side_select_input, .aux_control_bit3);

//--- sim/tb_serializer_link_config_regs.sv
// Self-checking bench for the link configuration registers
`timescale 1ns/1ps
module tb_serializer_link_config_regs
    import slcr_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic general_out_immunity_strap = 1'b0;
    logic high_bw_mode = 1'b0;
    logic de_in = 1'b1;
    logic hs_n_in = 1'b1;
    logic [1:0] dual_pin_in = 2'h0;
    logic [7:0] reg_rdata, rev_bit_cycles;
    logic [3:0] coax_swing_level;
    logic [1:0] ctrl_packet_trigger_sel;
    logic reg_rvalid, swing_code_bad, remote_wake_off, wake_rx_en;
    logic de_packet_trigger_off, ctrl_packet_send, rev_chan_pos_en;
    logic rev_chan_neg_en, robust_rev_chan_sel, robust_rev_rate_sel;
    logic pin_a_role_sel, pin_b_role_sel, mode_select_input;
    logic aux_control_bit0, link_side_select_input, aux_control_bit3;
    int err_count = 0;
    int n_compared = 0;
    int seed = 32'h9C6060E9;
    logic [7:0] mdl [8'h14:8'h1A];
    logic [7:0] amap [4] = '{ADDR_SWING, ADDR_TRIGGER, ADDR_IMMUNITY,
        ADDR_RATE_ROLES};

    slcr_regs dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reg_rvalid, .general_out_immunity_strap, .high_bw_mode,
        .de_in, .hs_n_in, .dual_pin_in, .coax_swing_level, .swing_code_bad,
        .remote_wake_off, .wake_rx_en, .de_packet_trigger_off,
        .ctrl_packet_trigger_sel, .ctrl_packet_send, .rev_chan_pos_en,
        .rev_chan_neg_en, .robust_rev_chan_sel, .robust_rev_rate_sel,
        .rev_bit_cycles, .pin_a_role_sel, .pin_b_role_sel, .mode_select_input,
        .aux_control_bit0, .link_side_select_input, .aux_control_bit3);

    // ********************
    // Helpers
    // ********************
    // Clock at 100 MHz
    always #5 clk = ~clk;

    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            ADDR_SWING: return 8'hF1;
            ADDR_TRIGGER: return 8'hF8;
            ADDR_IMMUNITY: return 8'h80;
            ADDR_RATE_ROLES: return 8'hB0;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] rd_exp(input logic [7:0] a);
        if (a < ADDR_SWING || a > ADDR_RATE_ROLES) begin
            return 8'h00;
        end
        return mdl[a];
    endfunction

    function automatic logic send_of(input int m, input logic h, d, s);
        return h & ((m[1:0] == 1) | (m[1:0] == 3 && !s)
            | (m[1:0] == 2 && !d && !m[2]));
    endfunction

    task automatic check(input string name, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Read-modify-write keeps reserved bits at their defaults
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] full;
        full = (mdl[a] & ~wmask(a)) | (d & wmask(a));
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= full;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        mdl[a] = full;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("rvalid", 16'(reg_rvalid), 16'h0001);
        check("rdata", 16'(reg_rdata), 16'(rd_exp(a)));
    endtask

    task automatic fields;
        check("fields", 16'({coax_swing_level, remote_wake_off,
            de_packet_trigger_off, ctrl_packet_trigger_sel, rev_chan_pos_en,
            rev_chan_neg_en, robust_rev_chan_sel, robust_rev_rate_sel,
            pin_a_role_sel, pin_b_role_sel}), 16'({mdl[8'h14][7:4],
            mdl[8'h14][0], mdl[8'h15][7:3], mdl[8'h17][7], mdl[8'h1A][7],
            mdl[8'h1A][5:4]}));
        check("cycles", 16'(rev_bit_cycles), 16'((mdl[8'h17][7]
            & mdl[8'h1A][7]) ? BIT_CYC_FAST : BIT_CYC_SLOW));
        check("wake", 16'({wake_rx_en, swing_code_bad}),
            16'({~mdl[8'h14][0], 1'b0}));
    endtask

    // Reset with a chosen strap level, then read every address back
    task automatic power_up(input logic strap);
        sys_rst <= 1'b1;
        high_bw_mode <= 1'b0;
        general_out_immunity_strap <= strap;
        mdl = '{8'hA0, 8'h52, 8'h00, {strap, 7'h1F}, 8'h00, 8'h4A, 8'h00};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (10) @(posedge clk);
        for (int i = 8'h13; i <= 8'h1B; i++) begin
            rd(8'(i));
        end
        fields;
    endtask

    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ********************
    // Main sequence
    // ********************
    initial begin
        logic [7:0] a, v;
        logic h, d, s;
        power_up(1'($random(seed)));
        for (int i = 1; i <= 10; i++) begin
            wr(ADDR_SWING, 8'(i << 4));
            rd(ADDR_SWING);
            fields;
        end
        repeat (40) begin
            a = amap[2'($random(seed))];
            v = 8'($random(seed));
            if (a == ADDR_SWING) begin
                v[7:4] = 4'(1 + {$random(seed)} % 10);
            end
            wr(a, v);
            rd(a);
            fields;
        end
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_TRIGGER, 8'(i << 5));
            repeat (6) begin
                h = 1'($random(seed));
                d = 1'($random(seed));
                s = 1'($random(seed));
                @(posedge clk);
                high_bw_mode <= h;
                de_in <= d;
                hs_n_in <= s;
                @(posedge clk);
                @(posedge clk);
                #1;
                check("send", 16'(ctrl_packet_send),
                    16'(send_of(i, h, d, s)));
            end
        end
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_RATE_ROLES, 8'({i[2], 1'b0, i[1:0], 4'h0}));
            @(posedge clk);
            dual_pin_in <= 2'($random(seed));
            repeat (8) @(posedge clk);
            #1;
            check("pins", 16'({mode_select_input, aux_control_bit0,
                link_side_select_input, aux_control_bit3}),
                16'({~i[1] & dual_pin_in[0], i[1] & dual_pin_in[0],
                ~i[0] & dual_pin_in[1], i[0] & dual_pin_in[1]}));
            fields;
        end
        // Second power-up with the strap level inverted
        @(posedge clk);
        power_up(~general_out_immunity_strap);
        final_report;
    end

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report;
    end
endmodule
